// [hdl/iacd_top.sv]
`timescale 1ns/1ps
`default_nettype none

module iacd_top #(
  parameter logic [7:0] MY_ADDR = iacd_pkg::MODULE_ADDR
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   rx_byte_valid,
  input  wire logic [7:0]             rx_byte_data,
  input  wire logic                   rx_frame_restart,
  input  wire logic                   accu_load,
  input  wire logic [31:0]            accu_load_data,
  input  wire logic                   xreg_load,
  input  wire logic [7:0]             xreg_load_data,
  input  wire logic                   par_rd_valid,
  input  wire logic [31:0]            par_rd_data,
  output var  iacd_pkg::iacd_par_req_t par_req,
  output var  logic                   vel_mode_set,
  output var  logic                   rot_left,
  output var  logic [7:0]             vel_mode_axis,
  output var  logic                   reply_valid,
  output var  iacd_pkg::iacd_reply_t  reply,
  output var  logic                   busy,
  output var  logic [31:0]            accu,
  output var  logic [7:0]             xreg
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    IACD_IDLE  = 3'b001,
    IACD_WRITE = 3'b010,
    IACD_READ  = 3'b100
  } iacd_fsm_t;

  typedef struct packed {
    iacd_fsm_t               fsm;
    logic [7:0]              op;
    iacd_pkg::iacd_par_req_t par;
    logic                    vmode;
    logic                    left;
    logic [7:0]              vaxis;
    logic                    rvalid;
    iacd_pkg::iacd_reply_t   rep;
    logic [31:0]             accu;
    logic [7:0]              xreg;
    logic                    busy;
  } iacd_state_t;

  iacd_state_t         s_q;
  iacd_state_t         s_d;
  logic                cmd_valid;
  logic                cmd_sum_ok;
  iacd_pkg::iacd_cmd_t cmd;
  logic                cmd_hit;
  logic                cmd_left;

  iacd_frame_rx u_rx (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .byte_valid    (rx_byte_valid),
    .byte_data     (rx_byte_data),
    .frame_restart (rx_frame_restart),
    .cmd_valid     (cmd_valid),
    .cmd_sum_ok    (cmd_sum_ok),
    .cmd           (cmd)
  );

  // ----------------------------------------
  // frame decode
  // ----------------------------------------
  // only a whole frame for this address starts a command
  assign cmd_hit  = cmd_valid && (cmd.addr == MY_ADDR);
  assign cmd_left = (cmd.op == iacd_pkg::OP_ROT_LEFT);

  // ----------------------------------------
  // command sequencing
  // ----------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.par.wr = 1'b0;
    s_d.par.rd = 1'b0;
    s_d.vmode  = 1'b0;
    s_d.rvalid = 1'b0;
    // software loads lose to a command that writes the same register
    if (accu_load) begin
      s_d.accu = accu_load_data;
    end
    if (xreg_load) begin
      s_d.xreg = xreg_load_data;
    end
    unique case (s_q.fsm)
      IACD_IDLE: begin
        // frames for another address are silently ignored
        if (cmd_hit) begin
          s_d.op       = cmd.op;
          s_d.rep.addr = MY_ADDR;
          s_d.rep.op   = cmd.op;
          s_d.rep.val  = iacd_pkg::VAL_ZERO;
          // axis comes from the index register, never from the motor field
          s_d.par.axis = s_q.xreg;
          s_d.vaxis    = s_q.xreg;
          if (!cmd_sum_ok) begin
            s_d.rvalid     = 1'b1;
            s_d.rep.status = iacd_pkg::ST_BAD_SUM;
          end else begin
            case (cmd.op)
              iacd_pkg::OP_ROT_LEFT, iacd_pkg::OP_ROT_RIGHT: begin
                // mode pulse now, parameter write one cycle later
                s_d.vmode    = 1'b1;
                s_d.left     = cmd_left;
                s_d.par.num  = iacd_pkg::PAR_TGT_VEL;
                s_d.par.data = s_q.accu;
                s_d.fsm      = IACD_WRITE;
              end
              iacd_pkg::OP_SOFT_STOP: begin
                s_d.vmode    = 1'b1;
                // a stop carries no direction; a stale one would mislead
                s_d.left     = 1'b0;
                s_d.par.num  = iacd_pkg::PAR_STOP_SPEED;
                s_d.par.data = iacd_pkg::VAL_ZERO;
                s_d.fsm      = IACD_WRITE;
              end
              iacd_pkg::OP_SET_PARAM: begin
                s_d.par.num  = cmd.typ;
                s_d.par.data = cmd.val;
                s_d.fsm      = IACD_WRITE;
              end
              iacd_pkg::OP_ACCU_PARAM: begin
                s_d.par.num  = cmd.typ;
                s_d.par.data = s_q.accu;
                s_d.fsm      = IACD_WRITE;
              end
              iacd_pkg::OP_GET_PARAM: begin
                s_d.par.num = cmd.typ;
                s_d.par.rd  = 1'b1;
                s_d.fsm     = IACD_READ;
              end
              default: begin
                s_d.rvalid     = 1'b1;
                s_d.rep.status = iacd_pkg::ST_BAD_OP;
              end
            endcase
          end
        end
      end
      IACD_WRITE: begin
        s_d.par.wr     = 1'b1;
        s_d.rvalid     = 1'b1;
        s_d.rep.status = iacd_pkg::ST_OK;
        s_d.fsm        = IACD_IDLE;
      end
      IACD_READ: begin
        // waits on the parameter store; no timeout, it must answer
        if (par_rd_valid) begin
          s_d.accu       = par_rd_data;
          s_d.rvalid     = 1'b1;
          s_d.rep.status = iacd_pkg::ST_OK;
          s_d.rep.val    = par_rd_data;
          s_d.fsm        = IACD_IDLE;
        end
      end
      default: begin
        s_d.fsm = IACD_IDLE;
      end
    endcase
    // busy leaves a flop so the output carries no decode behind it
    s_d.busy = (s_d.fsm != IACD_IDLE);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q     <= '0;
      s_q.fsm <= IACD_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from s_q
  // ----------------------------------------
  assign par_req       = s_q.par;
  assign vel_mode_set  = s_q.vmode;
  assign rot_left      = s_q.left;
  assign vel_mode_axis = s_q.vaxis;
  assign reply_valid   = s_q.rvalid;
  assign reply         = s_q.rep;
  assign busy          = s_q.busy;
  assign accu          = s_q.accu;
  assign xreg          = s_q.xreg;
endmodule // iacd_top

`default_nettype wire

// [hdl/iacd_frame_rx.sv]
// ----------------------------------------
// shared constants and carriers
// ----------------------------------------
package iacd_pkg;
  localparam logic [7:0]  OP_SET_PARAM   = 8'h10;
  localparam logic [7:0]  OP_GET_PARAM   = 8'h11;
  localparam logic [7:0]  OP_ACCU_PARAM  = 8'h12;
  localparam logic [7:0]  OP_ROT_LEFT    = 8'h34;
  localparam logic [7:0]  OP_ROT_RIGHT   = 8'h35;
  localparam logic [7:0]  OP_SOFT_STOP   = 8'h36;
  localparam logic [7:0]  ST_OK          = 8'h64;
  localparam logic [7:0]  ST_BAD_SUM     = 8'h01;
  localparam logic [7:0]  ST_BAD_OP      = 8'h02;
  localparam logic [7:0]  PAR_TGT_VEL    = 8'h02;
  localparam logic [7:0]  PAR_STOP_SPEED = 8'h00;
  localparam logic [31:0] VAL_ZERO       = 32'h0000_0000;
  localparam logic [3:0]  LAST_BYTE      = 4'h8;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [7:0]  MODULE_ADDR    = 8'h01;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  op;
    logic [7:0]  typ;
    logic [7:0]  mot;
    logic [31:0] val;
  } iacd_cmd_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  status;
    logic [7:0]  op;
    logic [31:0] val;
  } iacd_reply_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  axis;
    logic [7:0]  num;
    logic [31:0] data;
  } iacd_par_req_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module iacd_frame_rx (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  input  wire logic              frame_restart,
  output var  logic              cmd_valid,
  output var  logic              cmd_sum_ok,
  output var  iacd_pkg::iacd_cmd_t cmd
);
  typedef struct packed {
    logic [3:0]          cnt;
    logic [7:0]          sum;
    iacd_pkg::iacd_cmd_t cmd;
    logic                valid;
    logic                ok;
  } iacd_rx_state_t;

  iacd_rx_state_t s_q;
  iacd_rx_state_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.valid = 1'b0;
    if (frame_restart) begin
      s_d.cnt = '0;
      s_d.sum = '0;
    end else if (byte_valid) begin
      if (s_q.cnt == iacd_pkg::LAST_BYTE) begin
        s_d.valid = 1'b1;
        s_d.ok    = (s_q.sum == byte_data);
        s_d.cnt   = '0;
        s_d.sum   = '0;
      end else begin
        // bytes shift in address first, value msb first
        s_d.cmd = {s_q.cmd[55:0], byte_data};
        s_d.sum = s_q.sum + byte_data;
        s_d.cnt = s_q.cnt + iacd_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_valid  = s_q.valid;
  assign cmd_sum_ok = s_q.ok;
  assign cmd        = s_q.cmd;
endmodule // iacd_frame_rx

`default_nettype wire

// [tb/iacd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// host frame sender
// --------
module iacd_host_model (
  input  wire logic       clk_sys,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end
  task automatic send(input iacd_pkg::iacd_cmd_t c, input logic bad);
    logic [7:0] b [9];
    logic [7:0] s;
    b = '{c.addr, c.op, c.typ, c.mot, c.val[31:24], c.val[23:16], c.val[15:8],
          c.val[7:0], 8'h00};
    s = 8'h00;
    for (int k = 0; k < 8; k++) s = s + b[k];
    b[8] = bad ? ~s : s;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk_sys);
      byte_valid <= 1'b1;
      byte_data  <= b[k];
    end
    @(posedge clk_sys);
    byte_valid <= 1'b0;
    // released line never keeps the last byte
    byte_data  <= ~b[8];
  endtask
endmodule // iacd_host_model
`default_nettype wire

// [tb/iacd_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// port checker
// --------
module iacd_top_chk #(parameter logic [7:0] MY_ADDR = 8'h01) (
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire logic                    par_rd_valid,
  input wire logic [31:0]             par_rd_data,
  input wire iacd_pkg::iacd_par_req_t par_req,
  input wire logic                    vel_mode_set,
  input wire logic                    rot_left,
  input wire logic [7:0]              vel_mode_axis,
  input wire logic                    reply_valid,
  input wire iacd_pkg::iacd_reply_t   reply,
  input wire logic                    busy,
  input wire logic [31:0]             accu,
  input wire logic [7:0]              xreg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_vel_then_wr: assert property (vel_mode_set |=> par_req.wr && reply_valid)
    else $error("no write after velocity mode");
  a_vel_axis_x: assert property (vel_mode_set |-> vel_mode_axis == $past(xreg))
    else $error("velocity mode on wrong axis");
  a_left_target: assert property (
    vel_mode_set && rot_left |->
    par_req.num == iacd_pkg::PAR_TGT_VEL && par_req.data == $past(accu))
    else $error("rotate left target wrong");
  a_stop_zero: assert property (
    vel_mode_set && par_req.num == iacd_pkg::PAR_STOP_SPEED |->
    par_req.data == 32'h0000_0000 && !rot_left)
    else $error("stop speed not zero");
  a_read_axis: assert property (par_req.rd |-> busy && par_req.axis == $past(xreg))
    else $error("read on wrong axis");
  a_read_reply: assert property (
    busy && par_rd_valid |=> reply_valid &&
    reply.val == $past(par_rd_data) && accu == $past(par_rd_data))
    else $error("read value not returned");
  a_reply_pulse: assert property (reply_valid |=> !reply_valid)
    else $error("reply longer than one cycle");
  a_write_reply: assert property (
    par_req.wr |-> reply_valid && !busy && reply.addr == MY_ADDR)
    else $error("write without reply");
  c_left: cover property (vel_mode_set && rot_left);
  c_read: cover property (busy && par_rd_valid);
  c_bad: cover property (reply_valid && reply.status == iacd_pkg::ST_BAD_SUM);
endmodule // iacd_top_chk
bind iacd_top iacd_top_chk #(.MY_ADDR(MY_ADDR)) u_chk (.clk_sys(clk_sys),
  .resetn(resetn), .par_rd_valid(par_rd_valid), .par_rd_data(par_rd_data),
  .par_req(par_req), .vel_mode_set(vel_mode_set), .rot_left(rot_left),
  .vel_mode_axis(vel_mode_axis), .reply_valid(reply_valid), .reply(reply),
  .busy(busy), .accu(accu), .xreg(xreg));
`default_nettype wire

// [tb/iacd_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
// --------
// bench
// --------
module iacd_top_tb_top;
  localparam logic [31:0] ACC = 32'h8001_2345;
  localparam logic [7:0]  XR  = 8'h05;
  localparam logic [31:0] PV  = 32'h3C5A_0F96;
  logic clk_sys = 1'b0, resetn = 1'b0, bv, frm_rst = 1'b0;
  logic accu_load = 1'b0, xreg_load = 1'b0, par_rd_valid = 1'b0, sv, sl;
  logic [31:0] accu_load_data = 32'h0, par_rd_data = 32'h0, accu;
  logic [7:0]  xreg_load_data = 8'h00, bd, vel_mode_axis, xreg, sax;
  int err_total = 0, n_compared = 0, rd_cnt = 0, rd_dly = 1;
  iacd_pkg::iacd_par_req_t par_req, pq;
  iacd_pkg::iacd_reply_t   reply, rp;
  logic vel_mode_set, rot_left, reply_valid, busy;
  always #20 clk_sys = ~clk_sys;
  iacd_host_model u_host (.clk_sys(clk_sys), .byte_valid(bv), .byte_data(bd));
  iacd_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .rx_byte_valid(bv),
    .rx_byte_data(bd), .rx_frame_restart(frm_rst), .accu_load(accu_load),
    .accu_load_data(accu_load_data), .xreg_load(xreg_load),
    .xreg_load_data(xreg_load_data), .par_rd_valid(par_rd_valid),
    .par_rd_data(par_rd_data), .par_req(par_req), .vel_mode_set(vel_mode_set),
    .rot_left(rot_left), .vel_mode_axis(vel_mode_axis), .reply_valid(reply_valid),
    .reply(reply), .busy(busy), .accu(accu), .xreg(xreg));
  // parameter store answers after a chosen delay, line scrambled between answers
  always @(posedge clk_sys) begin
    if (rd_cnt == 1) begin
      par_rd_valid <= 1'b1;
      par_rd_data  <= PV;
    end else begin
      par_rd_valid <= 1'b0;
      par_rd_data  <= ~par_rd_data;
    end
    if (par_req.rd) rd_cnt <= rd_dly;
    else if (rd_cnt > 0) rd_cnt <= rd_cnt - 1;
  end
  task automatic print_verdict();
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, typ, input logic [31:0] v, input logic bad);
    int i;
    u_host.send('{iacd_pkg::MODULE_ADDR, op, typ, 8'hC3, v}, bad);
    {sv, sl, sax} = '0;
    pq = '0;
    for (i = 0; i < 60; i++) begin
      #1;
      if (vel_mode_set) {sv, sl, sax} = {1'b1, rot_left, vel_mode_axis};
      if (par_req.wr || par_req.rd) pq = par_req;
      if (reply_valid) break;
      @(posedge clk_sys);
    end
    rp = reply;
    if (i == 60) begin
      err_total++;
      $display("[ERR] %0t no reply", $time);
      print_verdict();
    end
  endtask
  task automatic t_motion();
    logic [7:0] ops [3] = '{iacd_pkg::OP_ROT_LEFT, iacd_pkg::OP_ROT_RIGHT,
                            iacd_pkg::OP_SOFT_STOP};
    for (int k = 0; k < 3; k++) begin
      run(ops[k], 8'h5A, 32'hDEAD_BEEF, 1'b0);
      `CHK({sv, sl, sax}, {1'b1, k == 0, XR})
      `CHK({pq.wr, pq.axis}, {1'b1, XR})
      `CHK({pq.num, pq.data}, k == 2 ? 40'h0 : {8'h02, ACC})
      `CHK({rp.status, rp.addr}, {iacd_pkg::ST_OK, 8'h01})
      `CHK({busy, rp.op}, {1'b0, ops[k]})
    end
  endtask
  task automatic t_set_accu();
    run(iacd_pkg::OP_SET_PARAM, 8'h04, 32'h0000_C800, 1'b0);
    `CHK({sv, pq.wr, pq.axis, pq.num, pq.data}, {2'b01, XR, 8'h04, 32'h0000_C800})
    `CHK(rp.status, iacd_pkg::ST_OK)
    run(iacd_pkg::OP_ACCU_PARAM, 8'h07, 32'h1111_2222, 1'b0);
    `CHK({pq.wr, pq.axis, pq.num, pq.data}, {1'b1, XR, 8'h07, ACC})
  endtask
  task automatic t_faults();
    run(iacd_pkg::OP_SET_PARAM, 8'h04, 32'h0000_0001, 1'b1);
    `CHK({pq.wr, rp.status}, {1'b0, iacd_pkg::ST_BAD_SUM})
    run(8'h37, 8'h00, 32'h0, 1'b0);
    `CHK(rp.status, iacd_pkg::ST_BAD_OP)
  endtask
  task automatic t_get();
    rd_dly = 5;
    run(iacd_pkg::OP_GET_PARAM, 8'h01, 32'h0, 1'b0);
    `CHK({pq.rd, pq.axis, pq.num}, {1'b1, XR, 8'h01})
    `CHK({rp.status, rp.val, accu}, {iacd_pkg::ST_OK, PV, PV})
    `CHK({busy, rp.op}, {1'b0, iacd_pkg::OP_GET_PARAM})
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    {accu_load, accu_load_data, xreg_load, xreg_load_data} <= {1'b1, ACC, 1'b1, XR};
    @(posedge clk_sys);
    {accu_load, xreg_load} <= 2'b00;
    @(posedge clk_sys);
    #1;
    `CHK({accu, xreg}, {ACC, XR})
    t_motion();
    t_set_accu();
    t_faults();
    t_get();
    print_verdict();
  end
endmodule // iacd_top_tb_top
`default_nettype wire
